// ==== hw/tbdo_pkg.sv ====
// Purpose: shared constants and types of the time base and buzzer divider block
// Assumes: classic wishbone slave with 32-bit data, byte address = 4 * register index
// Notes:   control register is 8 bits wide, upper bus bits read as zero
package tbdo_pkg;

	// register indices and byte addresses
	localparam logic [7:0] TBDO_CTRL_INDEX   = 8'h36;
	localparam logic [7:0] TBDO_STAT_INDEX   = 8'h37;
	localparam logic [7:0] TBDO_MASK_INDEX   = 8'h38;
	localparam logic [9:0] TBDO_CTRL_ADDR    = {TBDO_CTRL_INDEX, 2'b00};
	localparam logic [9:0] TBDO_STAT_ADDR    = {TBDO_STAT_INDEX, 2'b00};
	localparam logic [9:0] TBDO_MASK_ADDR    = {TBDO_MASK_INDEX, 2'b00};

	// control field positions
	localparam int         TBDO_BUZZ_EN_BIT  = 7;
	localparam int         TBDO_BUZZ_SEL_LSB = 5;
	localparam int         TBDO_SRC_SEL_BIT  = 4;
	localparam int         TBDO_TB_EN_BIT    = 3;
	localparam int         TBDO_IVAL_LSB     = 0;

	// values after reset
	localparam logic [7:0] TBDO_CTRL_RESET   = 8'h00;
	localparam logic [0:0] TBDO_STAT_RESET   = 1'h0;
	localparam logic [0:0] TBDO_MASK_RESET   = 1'h0;

	// divider chain lengths
	localparam int         TBDO_HF_WIDTH     = 23;
	localparam int         TBDO_LF_WIDTH     = 15;

	// status and mask layout: bit 0 is the time base tick
	localparam int         TBDO_EVT_TICK_BIT = 0;

	typedef struct packed {
		logic       buzzer_output_enable;
		logic [1:0] buzzer_frequency_select;
		logic       divider_source_select;
		logic       time_base_enable;
		logic [2:0] interval_select;
	} tbdo_ctrl_type;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [9:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} tbdo_wb_req_type;

endpackage

// ==== hw/tbdo_timer.sv ====
// Purpose: periodic time base interrupt, deep mode release and buzzer square wave
// Assumes: i_sys_clk is the high-frequency clock, i_low_freq_tick is one pulse per
//          low-frequency clock period, all inputs synchronous to i_sys_clk
// Notes:   wishbone classic slave, one wait state, ack pulse one cycle
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ns
module tbdo_timer (
	// clock, reset, clock enable
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_clk_en,
	// wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [9:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	// clock source and mode
	input  wire logic        i_low_freq_tick,
	input  wire logic        i_slow_mode,
	// events and pins
	output logic             o_time_base_interrupt,
	output logic             o_deep_wake_request,
	output logic             o_buzzer_output_pin,
	output logic             o_irq
);

	tbdo_pkg::tbdo_wb_req_type          req;
	tbdo_pkg::tbdo_ctrl_type            ctrl;
	logic [tbdo_pkg::TBDO_HF_WIDTH-1:0] hf_cnt;
	logic [tbdo_pkg::TBDO_LF_WIDTH-1:0] lf_cnt;
	logic                               lf_active;
	logic                               lf_prev;
	logic                               tb_tap;
	logic                               bz_tap;
	logic                               tb_prev;
	logic                               ctrl_wr_q;
	logic                               tb_fall;
	logic [0:0]                         status;
	logic [0:0]                         mask;
	logic [2:0]                         sel_hit;
	logic                               bus_go;
	logic                               wr_ctrl;
	logic                               wr_stat;
	logic                               wr_mask;
	logic [31:0]                        next_rdata;

	// interval tap from either chain
	function automatic logic pick_tb(input logic [2:0] code, input logic lf,
		input logic [tbdo_pkg::TBDO_HF_WIDTH-1:0] hf_c,
		input logic [tbdo_pkg::TBDO_LF_WIDTH-1:0] lf_c);
		logic t;
		t = 1'b0;
		if (lf) begin
			case (code)
				3'h0:    t = lf_c[14];
				3'h1:    t = lf_c[12];
				3'h2:    t = lf_c[7];
				3'h3:    t = lf_c[5];
				3'h4:    t = lf_c[4];
				3'h5:    t = lf_c[3];
				3'h6:    t = lf_c[2];
				default: t = lf_c[0];
			endcase
		end else begin
			case (code)
				3'h0:    t = hf_c[22];
				3'h1:    t = hf_c[20];
				3'h2:    t = hf_c[15];
				3'h3:    t = hf_c[13];
				3'h4:    t = hf_c[12];
				3'h5:    t = hf_c[11];
				3'h6:    t = hf_c[10];
				default: t = hf_c[8];
			endcase
		end
		return t;
	endfunction

	// buzzer tap from either chain
	function automatic logic pick_bz(input logic [1:0] code, input logic lf,
		input logic [tbdo_pkg::TBDO_HF_WIDTH-1:0] hf_c,
		input logic [tbdo_pkg::TBDO_LF_WIDTH-1:0] lf_c);
		logic t;
		t = 1'b0;
		case (code)
			2'h0:    t = lf ? lf_c[4] : hf_c[12];
			2'h1:    t = lf ? lf_c[3] : hf_c[11];
			2'h2:    t = lf ? lf_c[2] : hf_c[10];
			default: t = lf ? lf_c[1] : hf_c[9];
		endcase
		return t;
	endfunction

	// register select from a byte address: bit 0 control, bit 1 status, bit 2 mask
	function automatic logic [2:0] reg_select(input logic [9:0] adr);
		logic [2:0] hit;
		hit    = 3'h0;
		hit[0] = (adr == tbdo_pkg::TBDO_CTRL_ADDR);
		hit[1] = (adr == tbdo_pkg::TBDO_STAT_ADDR);
		hit[2] = (adr == tbdo_pkg::TBDO_MASK_ADDR);
		return hit;
	endfunction

	assign req = '{cyc: i_wb_cyc, stb: i_wb_stb, we: i_wb_we, adr: i_wb_adr,
		sel: i_wb_sel, dat: i_wb_dat};

	// a request is served once; ack drops in the cycle after it was given
	assign bus_go  = req.cyc & req.stb & ~o_wb_ack;
	assign sel_hit = reg_select(req.adr);
	assign wr_ctrl = bus_go & req.we & req.sel[0] & sel_hit[0];
	assign wr_stat = bus_go & req.we & req.sel[0] & sel_hit[1];
	assign wr_mask = bus_go & req.we & req.sel[0] & sel_hit[2];

	assign lf_active = ctrl.divider_source_select | i_slow_mode;
	assign tb_tap    = pick_tb(ctrl.interval_select, lf_active, hf_cnt, lf_cnt);
	assign bz_tap    = pick_bz(ctrl.buzzer_frequency_select, lf_active, hf_cnt, lf_cnt);

	// a control write or a source switch changes the tap, so that compare is not an edge
	assign tb_fall   = tb_prev & ~tb_tap & ~ctrl_wr_q & (lf_prev == lf_active);

	assign o_irq     = |(status & mask);

	// free-running divider chains, never cleared by software
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			hf_cnt <= '0;
			lf_cnt <= '0;
		end else if (i_clk_en) begin
			hf_cnt <= hf_cnt + 23'h1;
			if (i_low_freq_tick) begin
				lf_cnt <= lf_cnt + 15'h1;
			end
		end
	end

	// control register
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			ctrl      <= tbdo_pkg::TBDO_CTRL_RESET;
			ctrl_wr_q <= 1'b0;
		end else if (i_clk_en) begin
			ctrl_wr_q <= wr_ctrl;
			if (wr_ctrl) begin
				ctrl <= req.dat[7:0];
			end
		end
	end

	// falling-edge detector, interrupt and release request
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			tb_prev               <= 1'b0;
			lf_prev               <= 1'b0;
			o_time_base_interrupt <= 1'b0;
			o_deep_wake_request   <= 1'b0;
		end else if (i_clk_en) begin
			tb_prev               <= tb_tap;
			lf_prev               <= lf_active;
			o_time_base_interrupt <= ctrl.time_base_enable & tb_fall;
			o_deep_wake_request   <= ctrl.time_base_enable & tb_fall;
		end else begin
			o_time_base_interrupt <= o_time_base_interrupt;
		end
	end

	// buzzer pin: idles low while disabled
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_buzzer_output_pin <= 1'b0;
		end else if (i_clk_en) begin
			o_buzzer_output_pin <= ctrl.buzzer_output_enable & bz_tap;
		end
	end

	// sticky status, write one to clear; a new tick beats the clear
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			status <= tbdo_pkg::TBDO_STAT_RESET;
			mask   <= tbdo_pkg::TBDO_MASK_RESET;
		end else if (i_clk_en) begin
			if (o_time_base_interrupt) begin
				status[tbdo_pkg::TBDO_EVT_TICK_BIT] <= 1'b1;
			end else if (wr_stat && req.dat[tbdo_pkg::TBDO_EVT_TICK_BIT]) begin
				status[tbdo_pkg::TBDO_EVT_TICK_BIT] <= 1'b0;
			end
			if (wr_mask) begin
				mask <= req.dat[0:0];
			end
		end
	end

	// read mux; unmapped addresses read zero and still ack
	always_comb begin
		next_rdata = 32'h0;
		case (sel_hit)
			3'h1:    next_rdata = {24'h0, ctrl};
			3'h2:    next_rdata = {31'h0, status};
			3'h4:    next_rdata = {31'h0, mask};
			default: next_rdata = 32'h0;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0;
		end else if (i_clk_en) begin
			o_wb_ack <= bus_go;
			if (bus_go && !req.we) begin
				o_wb_dat <= next_rdata;
			end
		end
	end

	// checks
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);

	sequence s_tap_falls;
		i_clk_en && ctrl.time_base_enable && tb_prev && !tb_tap && !ctrl_wr_q;
	endsequence

	sequence s_ctrl_write_on;
		wr_ctrl && i_clk_en && i_wb_dat[3];
	endsequence

	sequence s_bus_taken;
		i_clk_en && bus_go;
	endsequence

	sequence s_source_moves;
		i_clk_en && (lf_active != lf_prev);
	endsequence

	a_irq_needs_enable: assert property (
		$rose(o_time_base_interrupt) |-> $past(ctrl.time_base_enable))
		else $error("interrupt while time base disabled");

	a_hf_tap_map: assert property (
		(!lf_active && ctrl.interval_select == 3'h4) |-> tb_tap == hf_cnt[12])
		else $error("wrong high-frequency interval tap");

	a_lf_tap_map: assert property (
		(lf_active && ctrl.interval_select == 3'h7) |-> tb_tap == lf_cnt[0])
		else $error("wrong low-frequency interval tap");

	a_irq_on_fall: assert property (
		s_tap_falls |=> o_time_base_interrupt)
		else $error("falling tap edge gave no interrupt");

	a_chain_runs_on: assert property (
		(wr_ctrl && i_clk_en) |=> hf_cnt == $past(hf_cnt) + 23'h1)
		else $error("divider chain disturbed by control write");

	a_combo_write: assert property (
		s_ctrl_write_on |=> ctrl.time_base_enable
			&& ctrl.interval_select == $past(i_wb_dat[2:0]) ##1 !o_time_base_interrupt)
		else $error("combined select and enable write mishandled");

	a_wake_with_irq: assert property (
		o_time_base_interrupt |-> o_deep_wake_request)
		else $error("release request missing with interrupt");

	a_buzz_follows: assert property (
		(i_clk_en && ctrl.buzzer_output_enable) |=> o_buzzer_output_pin == $past(bz_tap))
		else $error("buzzer pin does not follow its tap");

	a_reset_clear: assert property (@(posedge i_sys_clk) disable iff (1'b0)
		!i_rst_b |=> ctrl == 8'h00 && !o_buzzer_output_pin)
		else $error("control not cleared by reset");

	a_ctrl_readback: assert property (
		(bus_go && !i_wb_we && i_wb_adr == tbdo_pkg::TBDO_CTRL_ADDR && i_clk_en)
			|=> o_wb_ack && o_wb_dat[3] == ctrl.time_base_enable
			&& o_wb_dat[7] == ctrl.buzzer_output_enable)
		else $error("control readback layout wrong");

	a_buzz_map: assert property (
		(lf_active && ctrl.buzzer_frequency_select == 2'h3) |-> bz_tap == lf_cnt[1])
		else $error("wrong buzzer tap");

	a_wake_only_irq: assert property (
		o_deep_wake_request |-> o_time_base_interrupt)
		else $error("release request without interrupt");

	a_irq_off_disabled: assert property (
		(i_clk_en && !ctrl.time_base_enable) |=> !o_time_base_interrupt)
		else $error("interrupt after a disabled cycle");

	a_irq_one_cycle: assert property (
		(i_clk_en && o_time_base_interrupt) |=> !o_time_base_interrupt)
		else $error("interrupt pulse longer than one cycle");

	a_source_quiet: assert property (
		s_source_moves |=> !o_time_base_interrupt)
		else $error("source switch taken as a tap edge");

	a_buzz_idle: assert property (
		(i_clk_en && !ctrl.buzzer_output_enable) |=> !o_buzzer_output_pin)
		else $error("buzzer pin active while disabled");

	a_ctrl_lands: assert property (
		(wr_ctrl && i_clk_en) |=> ctrl == $past(i_wb_dat[7:0]))
		else $error("control write not stored");

	a_lf_holds: assert property (
		(i_clk_en && !i_low_freq_tick) |=> lf_cnt == $past(lf_cnt))
		else $error("low-frequency chain moved without a tick");

	a_status_sets: assert property (
		(i_clk_en && o_time_base_interrupt) |=> status[tbdo_pkg::TBDO_EVT_TICK_BIT])
		else $error("tick did not set status");

	a_status_holds: assert property (
		(i_clk_en && !o_time_base_interrupt && !wr_stat) |=> status == $past(status))
		else $error("status changed with no tick or clear");

	a_ack_answers: assert property (
		s_bus_taken |=> o_wb_ack)
		else $error("taken request not acknowledged");

	a_ack_one_cycle: assert property (
		(i_clk_en && o_wb_ack) |=> !o_wb_ack)
		else $error("ack longer than one cycle");

	a_reset_quiet: assert property (@(posedge i_sys_clk) disable iff (1'b0)
		!i_rst_b |=> !o_time_base_interrupt && !o_deep_wake_request && !o_wb_ack)
		else $error("outputs not cleared by reset");

	a_freeze_holds: assert property (
		!i_clk_en |=> hf_cnt == $past(hf_cnt) && ctrl == $past(ctrl)
			&& o_wb_ack == $past(o_wb_ack))
		else $error("state moved while clock enable low");

endmodule

// ==== tb/tbdo_far_end.sv ====
// Purpose: far side model: low-frequency clock source and interrupt taker
// Assumes: one tick pulse every i_period system clocks
// Notes:   counts interrupt pulses as the cpu side would take them
`timescale 1ns/1ns
module tbdo_far_end (
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_b,
	// low-frequency source
	input  wire logic [3:0]  i_period,
	output logic             o_low_freq_tick,
	// interrupt side
	input  wire logic        i_time_base_interrupt,
	output logic      [15:0] o_int_count
);
	logic [3:0] div;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b || div >= i_period - 4'h1) begin
			div <= 4'h0;
		end else begin
			div <= div + 4'h1;
		end
		o_low_freq_tick <= i_rst_b && (div >= i_period - 4'h1);
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_int_count <= 16'h0;
		end else begin
			o_int_count <= o_int_count + 16'(i_time_base_interrupt);
		end
	end
endmodule

// ==== tb/time_base_and_divider_output_test.sv ====
// Purpose: self-checking bench for the time base and buzzer divider block
// Assumes: one system clock, registers over classic wishbone
// Notes:   the far side model supplies the low-frequency tick
`timescale 1ns/1ns
module time_base_and_divider_output_test;
	logic                      clk, rst_b, slow, ack, tint, wake, buzz, irq, lft, k, en;
	logic [3:0]                per;
	logic [15:0]               nint;
	logic [31:0]               rdat, q;
	tbdo_pkg::tbdo_wb_req_type req;
	int                        n_mismatch = 0, compares = 0, cnt = 0;
	int                        c, hi, w, t0, tl, n0;
	int                        hexp[8] = '{23, 21, 16, 14, 13, 12, 11, 9};
	int                        lexp[8] = '{15, 13, 8, 6, 5, 4, 3, 1};

	tbdo_timer i_tbdo_timer (
		.i_sys_clk(clk), .i_rst_b(rst_b), .i_clk_en(en),
		.i_wb_cyc(req.cyc), .i_wb_stb(req.stb), .i_wb_we(req.we), .i_wb_adr(req.adr),
		.i_wb_sel(req.sel), .i_wb_dat(req.dat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_low_freq_tick(lft), .i_slow_mode(slow), .o_time_base_interrupt(tint),
		.o_deep_wake_request(wake), .o_buzzer_output_pin(buzz), .o_irq(irq));

	tbdo_far_end i_tbdo_far_end (
		.i_sys_clk(clk), .i_rst_b(rst_b), .i_period(per), .o_low_freq_tick(lft),
		.i_time_base_interrupt(tint), .o_int_count(nint));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) cnt <= cnt + 1;

	task automatic print_verdict();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one classic cycle, held until ack is sampled high
	task automatic wb(input logic wr, input logic [9:0] a, input logic [31:0] d);
		int n;
		n = 0;
		req <= '{cyc: 1'b1, stb: 1'b1, we: wr, adr: a, sel: 4'h1, dat: d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		req <= '0;
		if (ack !== 1'b1) begin
			n_mismatch++;
			$display("BAD %0t bus hang", $time);
			print_verdict();
		end
		@(posedge clk);
	endtask

	task automatic rd(input logic [9:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	// b=0 waits for an interrupt pulse, b=1 for a buzzer rising edge
	task automatic wait_evt(input logic b, input logic must, input int bound);
		logic prev;
		prev = buzz;
		c = 0;
		hi = 0;
		k = 1'b0;
		while (!k && c < bound) begin
			@(posedge clk);
			c++;
			hi += int'(buzz === 1'b1);
			k = b ? (buzz === 1'b1 && prev !== 1'b1) : (tint === 1'b1);
			w = int'(wake === 1'b1);
			prev = buzz;
		end
		tl = cnt;
		if (must && !k) begin
			n_mismatch++;
			$display("BAD %0t no event", $time);
			print_verdict();
		end
	endtask

	task automatic period(input logic b, input int exp, input int bound);
		wait_evt(b, 1'b1, bound);
		wait_evt(b, 1'b1, bound);
		chk(c, exp);
	endtask

	initial begin
		req = '0;
		en = 1'b1;
		rst_b = 1'b0;
		slow = 1'b0;
		per = 4'h4;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(tbdo_pkg::TBDO_CTRL_ADDR, 32'h0);
		rd(tbdo_pkg::TBDO_STAT_ADDR, 32'h0);
		rd(tbdo_pkg::TBDO_MASK_ADDR, 32'h0);
		wb(1'b1, 10'h3fc, 32'hff);
		rd(10'h3fc, 32'h0);
		wb(1'b1, tbdo_pkg::TBDO_CTRL_ADDR, 32'h77);
		rd(tbdo_pkg::TBDO_CTRL_ADDR, 32'h77);
		for (int i = 4; i < 8; i++) begin
			wb(1'b1, tbdo_pkg::TBDO_CTRL_ADDR, 32'(i) | 32'h8);
			period(1'b0, 1 << hexp[i], 20000);
			chk(w, 1);
			wb(1'b1, tbdo_pkg::TBDO_CTRL_ADDR, 32'(i));
		end
		t0 = tl;
		n0 = nint;
		wait_evt(1'b0, 1'b0, 1100);
		chk(k, 1'b0);
		chk(nint, n0);
		wb(1'b1, tbdo_pkg::TBDO_CTRL_ADDR, 32'hf);
		wait_evt(1'b0, 1'b1, 600);
		chk((tl - t0) % 512, 0);
		// 100 frozen cycles push the next tick back by exactly that much
		t0 = tl;
		en <= 1'b0;
		repeat (100) @(posedge clk);
		en <= 1'b1;
		wait_evt(1'b0, 1'b1, 700);
		chk(tl - t0, 612);
		rd(tbdo_pkg::TBDO_STAT_ADDR, 32'h1);
		chk(irq, 1'b0);
		wb(1'b1, tbdo_pkg::TBDO_MASK_ADDR, 32'h1);
		chk(irq, 1'b1);
		wb(1'b1, tbdo_pkg::TBDO_CTRL_ADDR, 32'h7);
		wb(1'b1, tbdo_pkg::TBDO_STAT_ADDR, 32'h1);
		rd(tbdo_pkg::TBDO_STAT_ADDR, 32'h0);
		chk(irq, 1'b0);
		for (int i = 2; i < 8; i++) begin
			wb(1'b1, tbdo_pkg::TBDO_CTRL_ADDR, 32'(i) | 32'h18);
			period(1'b0, 4 << lexp[i], 5000);
			wb(1'b1, tbdo_pkg::TBDO_CTRL_ADDR, 32'(i) | 32'h10);
		end
		slow <= 1'b1;
		per <= 4'h1;
		wb(1'b1, tbdo_pkg::TBDO_CTRL_ADDR, 32'h9);
		period(1'b0, 1 << 13, 20000);
		wb(1'b1, tbdo_pkg::TBDO_CTRL_ADDR, 32'h1);
		slow <= 1'b0;
		for (int s = 0; s < 4; s++) begin
			wb(1'b1, tbdo_pkg::TBDO_CTRL_ADDR, 32'h90 | 32'(s << 5));
			period(1'b1, 32 >> s, 300);
			chk(hi, 16 >> s);
			wb(1'b1, tbdo_pkg::TBDO_CTRL_ADDR, 32'h10 | 32'(s << 5));
		end
		chk(buzz, 1'b0);
		wb(1'b1, tbdo_pkg::TBDO_CTRL_ADDR, 32'he0);
		period(1'b1, 1024, 3000);
		chk(hi, 512);
		rst_b <= 1'b0;
		@(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(tbdo_pkg::TBDO_CTRL_ADDR, 32'h0);
		chk(buzz, 1'b0);
		print_verdict();
	end
endmodule
